// file: verification/mbc_cycle_test.sv
// mbc_cycle_test: self-checking bench of the bus cycle sequencer
// assumes mbc_device_model answers on the far side of the muxed bus
module mbc_cycle_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock, reset, narrow, req_valid, slow, req_taken, rdata_valid, mid_oe_n;
    logic addr_latch, read_n, write_n, mem_io, dir, buf_n, ready, enable;
    logic [3:0] n_wait, upper;
    logic [7:0] mid_addr;
    logic [15:0] rdata, ad_out, ad_oe_n, ad_pin, rd;
    logic [19:0] latched;
    mbc_pkg::mbc_req_t req;
    int n_fail, comparisons, cycles, len;
    mbc_cycle u_dut (.CLOCK(clock), .RESET(reset), .ENABLE(enable), .NARROW(narrow), .READY(ready),
        .REQ_VALID(req_valid), .REQ(req), .REQ_TAKEN(req_taken), .RDATA(rdata),
        .RDATA_VALID(rdata_valid), .AD_OUT(ad_out), .AD_OE_N(ad_oe_n), .AD_IN(ad_pin),
        .MID_ADDR(mid_addr), .MID_OE_N(mid_oe_n), .UPPER_ADDR_STATUS(upper), .ADDR_LATCH(addr_latch),
        .READ_N(read_n), .WRITE_N(write_n), .MEM_IO_SELECT(mem_io), .DATA_DIRECTION_SELECT(dir),
        .DATA_BUFFER_ENABLE_N(buf_n));
    mbc_device_model u_dev (.clock(clock), .narrow(narrow), .slow(slow), .n_wait(n_wait),
        .ad_out(ad_out), .ad_oe_n(ad_oe_n), .mid_addr(mid_addr), .upper(upper),
        .addr_latch(addr_latch), .read_n(read_n), .write_n(write_n), .ready(ready),
        .ad_pin(ad_pin), .latched(latched));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    task automatic do_reset(input logic nar);
        @(posedge clock);
        reset <= 1'b1;
        narrow <= nar;
        repeat (20) @(posedge clock);
        check("rst latch", addr_latch, 1'b0);
        check("rst strobes", {read_n, write_n, buf_n}, 3'b111);
        check("rst bus", ad_oe_n, 16'hffff);
        reset <= 1'b0;
    endtask
    // one whole cycle; len counts T2 to T4
    task automatic cyc(input logic wr, input logic io, input logic [19:0] a, input logic [15:0] wd);
        logic [15:0] m;
        logic [3:0] st;
        int n;
        m = narrow ? 16'h00ff : 16'hffff;
        st = mbc_pkg::STAT_BUSY_BIT | (io ? mbc_pkg::STAT_IO_BIT : 4'h0) | (wr ? mbc_pkg::STAT_WRITE_BIT : 4'h0);
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{wr, io, 1'b0, a, wd};
        n = 0;
        @(negedge clock);
        while (req_taken !== 1'b1 && n < 20) begin
            @(negedge clock);
            n++;
        end
        check("t1 strobe", addr_latch, 1'b1);
        check("t1 addr", {upper, ad_out & m, ad_oe_n & m}, {a[19:16], a[15:0] & m, 16'h0000});
        check("t1 read", read_n, 1'b1);
        check("t1 buffer", buf_n, 1'b1);
        @(posedge clock);
        req_valid <= 1'b0;
        @(negedge clock);
        check("t2 latch", addr_latch, 1'b0);
        check("t2 ctl", {read_n, write_n, buf_n, dir}, {wr, !wr, 1'b0, wr});
        check("mem io", mem_io, narrow ? io : !io);
        check("latched", latched, narrow ? a : {a[19:16], a[15:0]});
        len = 1;
        while ((read_n === 1'b0 || write_n === 1'b0) && len < 40) begin
            check("status", upper, st);
            check("lines", {ad_oe_n & m, wr ? ad_out & m : 16'h0000}, wr ? {16'h0000, wd & m} : {m, 16'h0000});
            if (narrow) begin
                check("middle", {mid_oe_n, mid_addr}, {1'b0, a[15:8]});
            end
            @(negedge clock);
            len++;
        end
        check("t4 ctl", {read_n, write_n, buf_n}, 3'b111);
        if (wr) begin
            check("t4 data", ad_out & m, wd & m);
        end
        // read data is registered as T4 ends; its valid pulse stands for one cycle
        @(negedge clock);
        check("t4 done", rdata_valid, !wr);
        check("rel bus", ad_oe_n, 16'hffff);
        rd = rdata;
    endtask
    // clock enable low: a pending request must not start a cycle
    task automatic t_freeze();
        @(posedge clock);
        enable <= 1'b0;
        req_valid <= 1'b1;
        req <= '{1'b0, 1'b0, 1'b0, 20'h00001, 16'h0000};
        repeat (5) begin
            @(negedge clock);
            check("frozen", {addr_latch, req_taken, read_n}, 3'b001);
        end
        @(posedge clock);
        req_valid <= 1'b0;
        enable <= 1'b1;
        @(negedge clock);
        @(negedge clock);
        check("thawed idle", {addr_latch, req_taken, read_n}, 3'b001);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_wide();
        do_reset(1'b0);
        cyc(1'b1, 1'b0, 20'h5a3c4, 16'h1234);
        check("w len", len, 3);
        cyc(1'b0, 1'b0, 20'h5a3c4, 16'h0000);
        check("r data", rd, 16'h1234);
        cyc(1'b0, 1'b1, 20'hc0017, 16'h0000);
        check("r io", {rd, 4'(len)}, {16'ha507, 4'h3});
        repeat (10) begin
            @(negedge clock);
            check("idle", {addr_latch, read_n, write_n}, 3'b011);
        end
    endtask
    task automatic t_wait();
        slow <= 1'b1;
        n_wait <= 4'h6;
        cyc(1'b1, 1'b1, 20'h3fffb, 16'hbeef);
        check("w wait", len > 3, 1'b1);
        cyc(1'b0, 1'b1, 20'h3fffb, 16'h0000);
        check("r wait", {rd, 1'(len > 3)}, {16'hbeef, 1'b1});
        slow <= 1'b0;
    endtask
    task automatic t_narrow();
        do_reset(1'b1);
        cyc(1'b1, 1'b0, 20'h9a5c2, 16'h7781);
        cyc(1'b0, 1'b1, 20'h9a5c2, 16'h0000);
        check("n data", rd, 16'h0081);
    endtask
    initial begin
        reset = 1'b1;
        narrow = 1'b0;
        req_valid = 1'b0;
        req = '0;
        slow = 1'b0;
        n_wait = 4'h0;
        enable = 1'b1;
        t_wide();
        t_freeze();
        t_wait();
        t_narrow();
        finish_test();
    end
endmodule

// file: verification/mbc_device_model.sv
// mbc_device_model: memory or io device behind an address latch on the muxed bus
// assumes it sees the sequencer's pins and resolves every shared line itself
module mbc_device_model (
    input wire logic clock, // system clock
    input wire logic narrow, // 8-bit data variant
    input wire logic slow, // hold ready low until n_wait
    input wire logic [3:0] n_wait, // cycles after T1 before ready
    input wire logic [15:0] ad_out, // sequencer driven value
    input wire logic [15:0] ad_oe_n, // low where sequencer drives
    input wire logic [7:0] mid_addr, // middle address lines
    input wire logic [3:0] upper, // upper address or status
    input wire logic addr_latch, // latch strobe
    input wire logic read_n, // read strobe
    input wire logic write_n, // write strobe
    output logic ready, // wait control
    output logic [15:0] ad_pin, // resolved line levels
    output logic [19:0] latched // demultiplexed address
);
    logic [15:0] mem [16];
    logic [15:0] last;
    logic [15:0] rd;
    logic [7:0] cnt;
    initial begin
        for (int i = 0; i < 16; i++) begin
            mem[i] = 16'ha500 + 16'(i);
        end
        last = 16'h0000;
        cnt = 8'hff;
        latched = 20'h00000;
    end
    // released lines show no stale value: inverse of the last level
    always_comb begin
        rd = mem[latched[3:0]];
        for (int i = 0; i < 16; i++) begin
            if (!ad_oe_n[i]) begin
                ad_pin[i] = ad_out[i];
            end else if (!read_n && (!narrow || i < 8)) begin
                ad_pin[i] = rd[i];
            end else begin
                ad_pin[i] = ~last[i];
            end
        end
    end
    assign ready = !slow || (cnt >= {4'h0, n_wait} && cnt < {4'h0, n_wait} + 8'h04);
    always @(posedge clock) begin
        last <= ad_pin;
        cnt <= addr_latch ? 8'h00 : (cnt == 8'hff ? cnt : cnt + 8'h01);
        if (addr_latch) begin
            latched <= narrow ? {upper, mid_addr, ad_pin[7:0]} : {upper, ad_pin};
        end
        if (!write_n) begin
            mem[latched[3:0]] <= narrow ? {8'h00, ad_pin[7:0]} : ad_pin;
        end
    end
endmodule

// file: verilog/mbc_cycle.sv
// mbc_cycle: minimum-mode bus cycle sequencer of the bus interface unit
// assumes requests come from same-clock logic; READY and the strap come from pins
module mbc_cycle (
    input wire logic CLOCK, // system clock
    input wire logic RESET, // asynchronous reset, active high
    input wire logic ENABLE, // clock enable; when low, freezes all state except REQ_TAKEN and RDATA_VALID, which clear
    input wire logic NARROW, // 1 selects the 8-bit data variant, static
    input wire logic READY, // wait control from the bus, asynchronous
    input wire logic REQ_VALID, // transfer request present
    input wire mbc_pkg::mbc_req_t REQ, // transfer request contents
    output logic REQ_TAKEN, // one-cycle pulse: request accepted in T1
    output logic [15:0] RDATA, // captured read data
    output logic RDATA_VALID, // one-cycle pulse: read data captured
    output logic [15:0] AD_OUT, // multiplexed address/data lines, driven value
    output logic [15:0] AD_OE_N, // low where a line is driven
    input wire logic [15:0] AD_IN, // multiplexed lines as seen on the pins
    output logic [7:0] MID_ADDR, // middle address byte lines of the narrow variant
    output logic MID_OE_N, // low while the middle address lines are driven
    output logic [3:0] UPPER_ADDR_STATUS, // upper address, then status
    output logic ADDR_LATCH, // address latch strobe, active high
    output logic READ_N, // read strobe, active low
    output logic WRITE_N, // write strobe, active low
    output logic MEM_IO_SELECT, // memory/io select, polarity per variant
    output logic DATA_DIRECTION_SELECT, // high transmit, low receive
    output logic DATA_BUFFER_ENABLE_N // transceiver enable, active low
);
    ////////////////////////////////////////////////////////////////////////
    // ready synchroniser and held request
    logic ready_sync;
    mbc_sync u_ready_sync (
        .clock(CLOCK),
        .reset(RESET),
        .enable(ENABLE),
        .din(READY),
        .dout(ready_sync)
    );

    logic [15:0] ad_in_s1;
    logic [15:0] ad_in_s2;
    logic [15:0] next_ad_in_s1;
    logic [15:0] next_ad_in_s2;

    mbc_pkg::mbc_state_t state;
    mbc_pkg::mbc_state_t next_state;
    mbc_pkg::mbc_req_t cur;
    mbc_pkg::mbc_req_t next_cur;

    always_comb begin
        next_ad_in_s1 = ENABLE ? AD_IN : ad_in_s1;
        next_ad_in_s2 = ENABLE ? ad_in_s1 : ad_in_s2;
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            ad_in_s1 <= mbc_pkg::DATA_RESET;
            ad_in_s2 <= mbc_pkg::DATA_RESET;
        end else begin
            ad_in_s1 <= next_ad_in_s1;
            ad_in_s2 <= next_ad_in_s2;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // cycle state machine
    always_comb begin
        next_state = state;
        next_cur = cur;
        if (ENABLE) begin
            case (state)
                mbc_pkg::MBC_TI: begin
                    if (REQ_VALID) begin
                        next_state = mbc_pkg::MBC_T1;
                        next_cur = REQ;
                    end
                end
                mbc_pkg::MBC_T1: next_state = mbc_pkg::MBC_T2;
                mbc_pkg::MBC_T2: next_state = mbc_pkg::MBC_T3;
                // ready sampled low at the end of T3 adds a wait state
                mbc_pkg::MBC_T3: next_state = ready_sync ? mbc_pkg::MBC_T4 : mbc_pkg::MBC_TW;
                mbc_pkg::MBC_TW: next_state = ready_sync ? mbc_pkg::MBC_T4 : mbc_pkg::MBC_TW;
                mbc_pkg::MBC_T4: begin
                    if (REQ_VALID) begin
                        next_state = mbc_pkg::MBC_T1;
                        next_cur = REQ;
                    end else begin
                        next_state = mbc_pkg::MBC_TI;
                    end
                end
                default: next_state = mbc_pkg::MBC_TI;
            endcase
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            state <= mbc_pkg::MBC_TI;
            cur <= '0;
        end else begin
            state <= next_state;
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin values for the state being entered, registered
    logic [15:0] next_ad_out;
    logic [15:0] next_ad_oe_n;
    logic [7:0] next_mid_addr;
    logic next_mid_oe_n;
    logic [3:0] next_upper;
    mbc_pkg::mbc_ctl_t next_ctl;
    logic [15:0] next_rdata;
    logic next_rdata_valid;
    logic next_req_taken;
    logic [3:0] status_code;

    always_comb begin
        status_code = mbc_pkg::STAT_BUSY_BIT;
        if (next_cur.fetch) status_code = status_code | mbc_pkg::STAT_FETCH_BIT;
        if (next_cur.write) status_code = status_code | mbc_pkg::STAT_WRITE_BIT;
        if (next_cur.io) status_code = status_code | mbc_pkg::STAT_IO_BIT;
        next_ad_out = AD_OUT;
        next_ad_oe_n = AD_OE_N;
        next_mid_addr = MID_ADDR;
        next_mid_oe_n = MID_OE_N;
        next_upper = UPPER_ADDR_STATUS;
        next_ctl = '{addr_latch: ADDR_LATCH, read: ~READ_N, write: ~WRITE_N,
                     buf_enable: ~DATA_BUFFER_ENABLE_N, transmit: DATA_DIRECTION_SELECT,
                     mem_io: MEM_IO_SELECT};
        next_rdata = RDATA;
        next_rdata_valid = 1'b0;
        next_req_taken = 1'b0;
        if (ENABLE) begin
            case (next_state)
                mbc_pkg::MBC_T1: begin
                    next_req_taken = 1'b1;
                    next_ad_out = next_cur.addr[15:0];
                    next_ad_oe_n = 16'h0000;
                    next_mid_addr = next_cur.addr[15:8];
                    next_mid_oe_n = 1'b0;
                    next_upper = next_cur.addr[19:16];
                    next_ctl.addr_latch = 1'b1;
                    next_ctl.read = 1'b0;
                    next_ctl.write = 1'b0;
                    next_ctl.buf_enable = 1'b0;
                    next_ctl.transmit = next_cur.write;
                    next_ctl.mem_io = NARROW ? next_cur.io : ~next_cur.io;
                end
                mbc_pkg::MBC_T2: begin
                    next_ctl.addr_latch = 1'b0;
                    next_upper = status_code;
                    next_ctl.buf_enable = 1'b1;
                    if (cur.write) begin
                        next_ad_out = NARROW ? {8'h00, cur.wdata[7:0]} : cur.wdata;
                        next_ad_oe_n = NARROW ? 16'hff00 : 16'h0000;
                        next_ctl.write = 1'b1;
                    end else begin
                        next_ad_oe_n = 16'hffff;
                        next_ctl.read = 1'b1;
                    end
                    if (NARROW) next_ad_oe_n[15:8] = 8'hff;
                end
                mbc_pkg::MBC_T3, mbc_pkg::MBC_TW: begin
                    next_upper = status_code;
                end
                mbc_pkg::MBC_T4: begin
                    next_ctl.read = 1'b0;
                    next_ctl.write = 1'b0;
                    next_ctl.buf_enable = 1'b0;
                end
                default: begin
                    next_ad_oe_n = 16'hffff;
                    next_mid_oe_n = 1'b1;
                    next_ctl.transmit = 1'b0;
                    next_upper = mbc_pkg::STAT_IDLE;
                end
            endcase
            if (state == mbc_pkg::MBC_T4 && next_state == mbc_pkg::MBC_TI) begin
                next_ad_oe_n = 16'hffff;
            end
            // taken as T4 ends: the pin flops then hold what the device drove two cycles before T4 (T2, T3 or a TW)
            if (state == mbc_pkg::MBC_T4 && !cur.write) begin
                next_rdata = NARROW ? {8'h00, ad_in_s2[7:0]} : ad_in_s2;
                next_rdata_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge CLOCK or posedge RESET) begin
        if (RESET) begin
            AD_OUT <= mbc_pkg::DATA_RESET;
            AD_OE_N <= 16'hffff;
            MID_ADDR <= 8'h00;
            MID_OE_N <= 1'b1;
            UPPER_ADDR_STATUS <= mbc_pkg::STAT_RESET;
            ADDR_LATCH <= 1'b0;
            READ_N <= 1'b1;
            WRITE_N <= 1'b1;
            MEM_IO_SELECT <= 1'b0;
            DATA_DIRECTION_SELECT <= 1'b0;
            DATA_BUFFER_ENABLE_N <= 1'b1;
            RDATA <= mbc_pkg::DATA_RESET;
            RDATA_VALID <= 1'b0;
            REQ_TAKEN <= 1'b0;
        end else begin
            AD_OUT <= next_ad_out;
            AD_OE_N <= next_ad_oe_n;
            MID_ADDR <= next_mid_addr;
            MID_OE_N <= next_mid_oe_n;
            UPPER_ADDR_STATUS <= next_upper;
            ADDR_LATCH <= next_ctl.addr_latch;
            READ_N <= ~next_ctl.read;
            WRITE_N <= ~next_ctl.write;
            MEM_IO_SELECT <= next_ctl.mem_io;
            DATA_DIRECTION_SELECT <= next_ctl.transmit;
            DATA_BUFFER_ENABLE_N <= ~next_ctl.buf_enable;
            RDATA <= next_rdata;
            RDATA_VALID <= next_rdata_valid;
            REQ_TAKEN <= next_req_taken;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic in_t1;
    assign in_t1 = (state == mbc_pkg::MBC_T1);

    cycle_order_a: assert property (@(posedge CLOCK) disable iff (RESET)
        (ENABLE && in_t1) ##1 ENABLE |-> state == mbc_pkg::MBC_T2)
        else $error("T1 not followed by T2");
    latch_pulse_a: assert property (@(posedge CLOCK) disable iff (RESET)
        ADDR_LATCH |-> in_t1) else $error("latch strobe outside T1");
    read_after_latch_a: assert property (@(posedge CLOCK) disable iff (RESET)
        $fell(READ_N) |-> $past(ADDR_LATCH)) else $error("read before latch");
    strobes_end_a: assert property (@(posedge CLOCK) disable iff (RESET)
        state == mbc_pkg::MBC_T4 |-> READ_N && WRITE_N) else $error("strobe active in T4");
    idle_released_a: assert property (@(posedge CLOCK) disable iff (RESET)
        state == mbc_pkg::MBC_TI && $past(state) == mbc_pkg::MBC_TI |-> AD_OE_N == 16'hffff && READ_N && WRITE_N)
        else $error("bus driven while idle");
    read_float_a: assert property (@(posedge CLOCK) disable iff (RESET)
        state == mbc_pkg::MBC_T2 && !cur.write |-> AD_OE_N == 16'hffff) else $error("read bus not floated");
    wait_hold_a: assert property (@(posedge CLOCK) disable iff (RESET)
        state == mbc_pkg::MBC_TW && $past(ENABLE) |-> $stable(AD_OUT) && $stable(AD_OE_N))
        else $error("bus changed in wait");
    buffer_isolate_a: assert property (@(posedge CLOCK) disable iff (RESET)
        in_t1 |-> DATA_BUFFER_ENABLE_N) else $error("buffer on during T1");
    status_phase_a: assert property (@(posedge CLOCK) disable iff (RESET)
        state == mbc_pkg::MBC_T3 |-> UPPER_ADDR_STATUS[3]) else $error("no status in T3");
endmodule

// file: verilog/mbc_pkg.sv
// mbc_pkg: constants and carrier types of the multiplexed bus cycle sequencer
// assumes one system clock at 100 MHz and an asynchronous active-high reset
package mbc_pkg;
    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;
    localparam int STAT_W = 4;
    localparam int SYNC_STAGES = 2;
    localparam logic [19:0] ADDR_RESET = 20'h00000;
    localparam logic [15:0] DATA_RESET = 16'h0000;
    localparam logic [3:0] STAT_RESET = 4'h0;
    localparam logic [3:0] STAT_IDLE = 4'h0;
    localparam logic [3:0] STAT_FETCH_BIT = 4'h1;
    localparam logic [3:0] STAT_WRITE_BIT = 4'h2;
    localparam logic [3:0] STAT_IO_BIT = 4'h4;
    localparam logic [3:0] STAT_BUSY_BIT = 4'h8;

    typedef enum logic [2:0] {
        MBC_TI = 3'b000,
        MBC_T1 = 3'b001,
        MBC_T2 = 3'b010,
        MBC_T3 = 3'b011,
        MBC_TW = 3'b100,
        MBC_T4 = 3'b101
    } mbc_state_t;

    // one transfer request from the execution unit or the prefetch queue
    typedef struct packed {
        logic write;
        logic io;
        logic fetch;
        logic [19:0] addr;
        logic [15:0] wdata;
    } mbc_req_t;

    // bus control strobes, all active high inside the block
    typedef struct packed {
        logic addr_latch;
        logic read;
        logic write;
        logic buf_enable;
        logic transmit;
        logic mem_io;
    } mbc_ctl_t;
endpackage

// file: verilog/mbc_sync.sv
// mbc_sync: two-flop synchroniser for one level from outside the clock domain
// assumes the level may change at any time relative to CLOCK
module mbc_sync (
    input wire logic clock, // system clock
    input wire logic reset, // asynchronous reset, active high
    input wire logic enable, // clock enable
    input wire logic din, // asynchronous level
    output logic dout // synchronised level
);
    logic stage_a;
    logic next_stage_a;
    logic next_dout;

    always_comb begin
        next_stage_a = enable ? din : stage_a;
        next_dout = enable ? stage_a : dout;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage_a <= 1'b0;
            dout <= 1'b0;
        end else begin
            stage_a <= next_stage_a;
            dout <= next_dout;
        end
    end
endmodule
